// file: inc/exc_ctrl_pkg.sv
// Constants and types shared by the reset and interrupt exception controller
package exc_ctrl_pkg;

    // ----------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ----------------------------------------------------------------
    localparam logic [15:0] IDX_WAKEUP_EDGE_SELECT = 16'hff90;
    localparam logic [15:0] IDX_REQUEST_PIN_EDGE_SELECT = 16'hfff2;
    localparam logic [15:0] IDX_INTERRUPT_ENABLE_FIRST = 16'hfff3;
    localparam logic [15:0] IDX_INTERRUPT_ENABLE_SECOND = 16'hfff4;
    localparam logic [15:0] IDX_INTERRUPT_FLAGS_FIRST = 16'hfff6;
    localparam logic [15:0] IDX_INTERRUPT_FLAGS_SECOND = 16'hfff7;
    localparam logic [15:0] IDX_WAKEUP_REQUEST_FLAGS = 16'hfff9;

    // ----------------------------------------------------------------
    // Values after reset
    // ----------------------------------------------------------------
    localparam logic [7:0] RST_WAKEUP_EDGE_SELECT = 8'h00;
    localparam logic [7:0] RST_REQUEST_PIN_EDGE_SELECT = 8'he0;
    localparam logic [7:0] RST_INTERRUPT_ENABLE = 8'h00;
    localparam logic [7:0] RST_INTERRUPT_FLAGS_FIRST = 8'h20;
    localparam logic [7:0] RST_INTERRUPT_FLAGS_SECOND = 8'h00;
    localparam logic [7:0] RST_WAKEUP_REQUEST_FLAGS = 8'h00;
    localparam logic [7:0] EDGE_SELECT_FIXED_ONES = 8'he0;
    localparam logic [7:0] FLAGS_FIRST_FIXED_ONES = 8'h20;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int EN1_TIMER_A = 7;
    localparam int EN1_SERIAL_ONE = 6;
    localparam int EN1_WAKEUP = 5;
    localparam int EN2_DIRECT_XFER = 7;
    localparam int EN2_CONVERTER = 6;
    localparam int EN2_TIMER_G = 4;
    localparam int EN2_TIMER_FH = 3;
    localparam int EN2_TIMER_FL = 2;
    localparam int EN2_TIMER_C = 1;
    localparam int EN2_ASYNC_COUNTER = 0;

    // ----------------------------------------------------------------
    // Vector numbers and sizes
    // ----------------------------------------------------------------
    localparam logic [4:0] VEC_RESET = 5'h00;
    localparam logic [4:0] VEC_FIRST_REQUEST_PIN = 5'h04;
    localparam logic [4:0] VEC_WAKEUP = 5'h09;
    localparam logic [4:0] VEC_TIMER_C = 5'h0d;
    localparam logic [4:0] VEC_DIRECT_XFER = 5'h14;
    localparam int VEC_LOWEST_USED = 4;
    localparam int VEC_COUNT = 21;
    localparam int NUM_REQUEST_PINS = 5;
    localparam int NUM_WAKEUP_PINS = 8;
    localparam int NUM_INTERNAL = 24;

    // Exception sequencer states, Gray coded along the reset path
    typedef enum logic [1:0] {
        ST_RESET = 2'b00,
        ST_FETCH = 2'b01,
        ST_FIRST = 2'b11,
        ST_RUN = 2'b10
    } seq_state_type;

endpackage

// file: logic/exc_ctrl.sv
// Reset and interrupt exception controller with APB register access
// Functional notes
// - Reset outranks every interrupt; reset state overrides all else.
// - Interrupts start only at an instruction or exception boundary.
// - While the reset pin is low all processing halts in reset state.
// - Reset initialises core and peripherals and sets the mask bit.
// - Program counter loads from reset vector at address zero.
// - No interrupt is taken before the first instruction after reset.
// - Thirteen external sources and twenty-four internal sources.
// - Highest fixed priority pending request is serviced first.
// - Mask bit set still lets flags set but blocks acceptance.
// - Each request and wake-up pin selects rising or falling edge.
// - Vector n sits at address 2n with the documented assignments.
// - Vector addresses two through seven are never produced.
// - Flag registers clear by writing zero; writing one keeps flags.
// - Edge select zero means falling, one rising; reset value zero.
// - Enable one lets a source request, zero blocks; reset zero. Vectors 17 and 18 have no enable here and request directly.
// - Upper three request-pin edge-select bits read one and ignore writes.
`timescale 1ns/1ps
module exc_ctrl
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [17:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [4:0] i_request_pin,
    input wire logic [7:0] i_wakeup_pin,
    input wire logic [23:0] i_internal_src,
    input wire logic i_insn_boundary,
    input wire logic i_cond_code_ibit,
    output logic o_core_hold,
    output logic o_periph_init,
    output logic o_ibit_set,
    output logic o_pc_load,
    output logic o_int_start,
    output logic [4:0] o_vector_num,
    output logic [15:0] o_vector_addr
);

    // ----------------------------------------------------------------
    // Helper functions
    // ----------------------------------------------------------------

    // Match an APB word address against a register index
    function automatic logic hit(input logic [17:0] addr, input logic [15:0] idx);
        hit = (addr[17:2] == idx) && (addr[1:0] == 2'b00);
    endfunction

    // Lowest numbered pending vector wins
    function automatic logic [4:0] pick(input logic [20:0] req);
        logic [4:0] v;
        v = exc_ctrl_pkg::VEC_RESET;
        for (int i = exc_ctrl_pkg::VEC_COUNT - 1; i >= exc_ctrl_pkg::VEC_LOWEST_USED; i--)
        begin
            if (req[i])
            begin
                v = 5'(i);
            end
        end
        pick = v;
    endfunction

    // ----------------------------------------------------------------
    // Declarations
    // ----------------------------------------------------------------
    logic [4:0] req_s1_q;
    logic [4:0] req_s2_q;
    logic [4:0] req_s3_q;
    logic [7:0] wkp_s1_q;
    logic [7:0] wkp_s2_q;
    logic [7:0] wkp_s3_q;
    logic [7:0] src_prev_q;
    logic [7:0] wakeup_edge_select_q;
    logic [4:0] request_pin_edge_select_q;
    logic [7:0] interrupt_enable_first_q;
    logic [7:0] interrupt_enable_second_q;
    logic [7:0] flags_first_q;
    logic [7:0] flags_second_q;
    logic [7:0] wakeup_flags_q;
    logic [4:0] req_edge;
    logic [7:0] wkp_edge;
    logic [7:0] src_first_set;
    logic [7:0] src_second_set;
    logic [20:0] vec_req;
    logic any_req;
    logic wr_en;
    logic [7:0] wdat;
    exc_ctrl_pkg::seq_state_type state_q;
    exc_ctrl_pkg::seq_state_type state_d;

    // ----------------------------------------------------------------
    // Pin synchronisers and edge detection
    // ----------------------------------------------------------------

    // Two flops before use, a third to find the edge
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            req_s1_q <= 5'h00;
            req_s2_q <= 5'h00;
            req_s3_q <= 5'h00;
            wkp_s1_q <= 8'h00;
            wkp_s2_q <= 8'h00;
            wkp_s3_q <= 8'h00;
        end
        else
        begin
            req_s1_q <= i_request_pin;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
            wkp_s1_q <= i_wakeup_pin;
            wkp_s2_q <= wkp_s1_q;
            wkp_s3_q <= wkp_s2_q;
        end
    end

    // Select 1 takes the rising edge, 0 the falling edge
    always_comb
    begin
        for (int i = 0; i < exc_ctrl_pkg::NUM_REQUEST_PINS; i++)
        begin
            req_edge[i] = request_pin_edge_select_q[i] ? (req_s2_q[i] & ~req_s3_q[i])
                                                       : (~req_s2_q[i] & req_s3_q[i]);
        end
        for (int i = 0; i < exc_ctrl_pkg::NUM_WAKEUP_PINS; i++)
        begin
            wkp_edge[i] = wakeup_edge_select_q[i] ? (wkp_s2_q[i] & ~wkp_s3_q[i])
                                                  : (~wkp_s2_q[i] & wkp_s3_q[i]);
        end
    end

    // Internal sources with a flag here, all but source 0, are caught on their rising edge
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            src_prev_q <= 8'h00;
        end
        else
        begin
            src_prev_q <= {i_internal_src[23:22], |i_internal_src[9:8], |i_internal_src[7:6],
                           |i_internal_src[5:4], i_internal_src[3:1]};
        end
    end

    // Map peripheral events onto flag bits
    always_comb
    begin
        src_first_set = {i_internal_src[1] & ~src_prev_q[0], i_internal_src[0], 1'b0, req_edge};
        src_second_set = {i_internal_src[23] & ~src_prev_q[7], i_internal_src[22] & ~src_prev_q[6],
                          1'b0,
                          (|i_internal_src[9:8]) & ~src_prev_q[5],
                          (|i_internal_src[7:6]) & ~src_prev_q[4],
                          (|i_internal_src[5:4]) & ~src_prev_q[3],
                          i_internal_src[3] & ~src_prev_q[2],
                          i_internal_src[2] & ~src_prev_q[1]};
    end

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    assign wr_en = i_psel & i_penable & o_pready & i_pwrite;
    assign wdat = i_pwdata[7:0];

    // One wait-free access phase; read data and error prepared in setup
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h00000000;
        end
        else
        begin
            o_pready <= i_psel & ~i_penable;
            o_pslverr <= 1'b0;
            o_prdata <= 32'h00000000;
            if (i_psel && !i_penable)
            begin
                if (hit(i_paddr, exc_ctrl_pkg::IDX_WAKEUP_EDGE_SELECT))
                    o_prdata <= {24'h000000, wakeup_edge_select_q};
                else if (hit(i_paddr, exc_ctrl_pkg::IDX_REQUEST_PIN_EDGE_SELECT))
                    o_prdata <= {24'h000000, exc_ctrl_pkg::EDGE_SELECT_FIXED_ONES[7:5],
                                 request_pin_edge_select_q};
                else if (hit(i_paddr, exc_ctrl_pkg::IDX_INTERRUPT_ENABLE_FIRST))
                    o_prdata <= {24'h000000, interrupt_enable_first_q};
                else if (hit(i_paddr, exc_ctrl_pkg::IDX_INTERRUPT_ENABLE_SECOND))
                    o_prdata <= {24'h000000, interrupt_enable_second_q};
                else if (hit(i_paddr, exc_ctrl_pkg::IDX_INTERRUPT_FLAGS_FIRST))
                    o_prdata <= {24'h000000, flags_first_q};
                else if (hit(i_paddr, exc_ctrl_pkg::IDX_INTERRUPT_FLAGS_SECOND))
                    o_prdata <= {24'h000000, flags_second_q};
                else if (hit(i_paddr, exc_ctrl_pkg::IDX_WAKEUP_REQUEST_FLAGS))
                    o_prdata <= {24'h000000, wakeup_flags_q};
                else
                    o_pslverr <= 1'b1;
            end
        end
    end

    // Edge select and enable registers, all cleared by reset
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            wakeup_edge_select_q <= exc_ctrl_pkg::RST_WAKEUP_EDGE_SELECT;
            request_pin_edge_select_q <= exc_ctrl_pkg::RST_REQUEST_PIN_EDGE_SELECT[4:0];
            interrupt_enable_first_q <= exc_ctrl_pkg::RST_INTERRUPT_ENABLE;
            interrupt_enable_second_q <= exc_ctrl_pkg::RST_INTERRUPT_ENABLE;
        end
        else if (wr_en)
        begin
            if (hit(i_paddr, exc_ctrl_pkg::IDX_WAKEUP_EDGE_SELECT))
                wakeup_edge_select_q <= wdat;
            if (hit(i_paddr, exc_ctrl_pkg::IDX_REQUEST_PIN_EDGE_SELECT))
                request_pin_edge_select_q <= wdat[4:0];
            if (hit(i_paddr, exc_ctrl_pkg::IDX_INTERRUPT_ENABLE_FIRST))
                interrupt_enable_first_q <= wdat;
            if (hit(i_paddr, exc_ctrl_pkg::IDX_INTERRUPT_ENABLE_SECOND))
                interrupt_enable_second_q <= wdat;
        end
    end

    // Flags: a write of 0 clears, 1 keeps; a new event beats the clear
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            flags_first_q <= exc_ctrl_pkg::RST_INTERRUPT_FLAGS_FIRST;
            flags_second_q <= exc_ctrl_pkg::RST_INTERRUPT_FLAGS_SECOND;
            wakeup_flags_q <= exc_ctrl_pkg::RST_WAKEUP_REQUEST_FLAGS;
        end
        else
        begin
            flags_first_q <= (wr_en && hit(i_paddr, exc_ctrl_pkg::IDX_INTERRUPT_FLAGS_FIRST)
                              ? (flags_first_q & wdat) : flags_first_q)
                             | src_first_set | exc_ctrl_pkg::FLAGS_FIRST_FIXED_ONES;
            flags_second_q <= (wr_en && hit(i_paddr, exc_ctrl_pkg::IDX_INTERRUPT_FLAGS_SECOND)
                               ? (flags_second_q & wdat) : flags_second_q)
                              | src_second_set;
            wakeup_flags_q <= (wr_en && hit(i_paddr, exc_ctrl_pkg::IDX_WAKEUP_REQUEST_FLAGS)
                               ? (wakeup_flags_q & wdat) : wakeup_flags_q)
                              | wkp_edge;
        end
    end

    // ----------------------------------------------------------------
    // Request gathering by vector
    // ----------------------------------------------------------------

    // Flags set regardless of the mask bit; enables gate each request except vectors 17 and 18
    always_comb
    begin
        vec_req = 21'h000000;
        for (int i = 0; i < exc_ctrl_pkg::NUM_REQUEST_PINS; i++)
        begin
            vec_req[int'(exc_ctrl_pkg::VEC_FIRST_REQUEST_PIN) + i] =
                flags_first_q[i] & interrupt_enable_first_q[i];
        end
        vec_req[exc_ctrl_pkg::VEC_WAKEUP] =
            (|wakeup_flags_q) & interrupt_enable_first_q[exc_ctrl_pkg::EN1_WAKEUP];
        vec_req[10] = flags_first_q[6] & interrupt_enable_first_q[exc_ctrl_pkg::EN1_SERIAL_ONE];
        vec_req[11] = flags_first_q[7] & interrupt_enable_first_q[exc_ctrl_pkg::EN1_TIMER_A];
        vec_req[12] = flags_second_q[0] & interrupt_enable_second_q[exc_ctrl_pkg::EN2_ASYNC_COUNTER];
        vec_req[exc_ctrl_pkg::VEC_TIMER_C] =
            flags_second_q[1] & interrupt_enable_second_q[exc_ctrl_pkg::EN2_TIMER_C];
        vec_req[14] = flags_second_q[2] & interrupt_enable_second_q[exc_ctrl_pkg::EN2_TIMER_FL];
        vec_req[15] = flags_second_q[3] & interrupt_enable_second_q[exc_ctrl_pkg::EN2_TIMER_FH];
        vec_req[16] = flags_second_q[4] & interrupt_enable_second_q[exc_ctrl_pkg::EN2_TIMER_G];
        vec_req[17] = |i_internal_src[15:10];
        vec_req[18] = |i_internal_src[21:16];
        vec_req[19] = flags_second_q[6] & interrupt_enable_second_q[exc_ctrl_pkg::EN2_CONVERTER];
        vec_req[exc_ctrl_pkg::VEC_DIRECT_XFER] =
            flags_second_q[7] & interrupt_enable_second_q[exc_ctrl_pkg::EN2_DIRECT_XFER];
        any_req = |vec_req[20:exc_ctrl_pkg::VEC_LOWEST_USED];
    end

    // ----------------------------------------------------------------
    // Exception sequencer
    // ----------------------------------------------------------------

    // Reset state, vector fetch, first instruction, then normal run
    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            exc_ctrl_pkg::ST_RESET: state_d = exc_ctrl_pkg::ST_FETCH;
            exc_ctrl_pkg::ST_FETCH: state_d = exc_ctrl_pkg::ST_FIRST;
            exc_ctrl_pkg::ST_FIRST:
                if (i_insn_boundary)
                    state_d = exc_ctrl_pkg::ST_RUN;
            exc_ctrl_pkg::ST_RUN: state_d = exc_ctrl_pkg::ST_RUN;
        endcase
    end

    // Asynchronous reset forces the reset state at once
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
            state_q <= exc_ctrl_pkg::ST_RESET;
        else
            state_q <= state_d;
    end

    // Core and peripheral control outputs
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_core_hold <= 1'b1;
            o_periph_init <= 1'b1;
            o_ibit_set <= 1'b0;
            o_pc_load <= 1'b0;
        end
        else
        begin
            o_core_hold <= 1'b0;
            o_periph_init <= 1'b0;
            o_ibit_set <= (state_q == exc_ctrl_pkg::ST_RESET);
            o_pc_load <= (state_q == exc_ctrl_pkg::ST_RESET);
        end
    end

    // Vector outputs: reset vector on fetch, interrupt at a boundary
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_int_start <= 1'b0;
            o_vector_num <= exc_ctrl_pkg::VEC_RESET;
            o_vector_addr <= 16'h0000;
        end
        else
        begin
            o_int_start <= 1'b0;
            if (state_q == exc_ctrl_pkg::ST_RESET)
            begin
                o_vector_num <= exc_ctrl_pkg::VEC_RESET;
                o_vector_addr <= 16'h0000;
            end
            else if (state_q == exc_ctrl_pkg::ST_RUN && i_insn_boundary && any_req
                     && !i_cond_code_ibit)
            begin
                o_int_start <= 1'b1;
                o_vector_num <= pick(vec_req);
                o_vector_addr <= {10'h000, pick(vec_req), 1'b0};
            end
        end
    end

endmodule // exc_ctrl

// file: verif/exc_ctrl_properties.sv
// Port-level assertions for the exception controller
`timescale 1ns/1ps
module exc_ctrl_properties
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [17:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic [4:0] i_request_pin,
    input wire logic [7:0] i_wakeup_pin,
    input wire logic [23:0] i_internal_src,
    input wire logic i_insn_boundary,
    input wire logic i_cond_code_ibit,
    input wire logic o_core_hold,
    input wire logic o_periph_init,
    input wire logic o_ibit_set,
    input wire logic o_pc_load,
    input wire logic o_int_start,
    input wire logic [4:0] o_vector_num,
    input wire logic [15:0] o_vector_addr
);
    // ----------------------------------------------------------------
    // Helper and assertions
    // ----------------------------------------------------------------
    logic seen_q;

    // Notes that the core finished an instruction since reset
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
            seen_q <= 1'b0;
        else if (i_insn_boundary && !o_core_hold)
            seen_q <= 1'b1;
    end

    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);

    reset_hold_a: assert property (disable iff (1'b0) !i_reset_n |-> o_core_hold && o_periph_init)
        else $error("core not held during reset");
    reset_first_a: assert property (disable iff (1'b0) !i_reset_n |-> !o_int_start && o_vector_num == 5'h00)
        else $error("interrupt activity during reset");
    init_seq_a: assert property ($rose(i_reset_n) |=> o_ibit_set && o_pc_load && o_vector_addr == 16'h0000)
        else $error("reset vector sequence missing");
    init_pulse_a: assert property (o_ibit_set |=> !o_ibit_set && !o_pc_load && !o_core_hold)
        else $error("init pulse too long");
    first_insn_a: assert property (o_int_start |-> seen_q)
        else $error("interrupt before first instruction");
    mask_block_a: assert property (i_cond_code_ibit |=> !o_int_start)
        else $error("interrupt taken while masked");
    insn_boundary_a: assert property (!i_insn_boundary |=> !o_int_start)
        else $error("interrupt taken mid instruction");
    vector_range_a: assert property (o_int_start |-> o_vector_num inside {[5'h04:5'h14]} && o_vector_addr == {10'h000, o_vector_num, 1'b0})
        else $error("bad vector");
    edge_fixed_a: assert property (i_psel && i_penable && o_pready && !i_pwrite && i_paddr == 18'h3ffc8 |-> o_prdata[7:5] == 3'b111)
        else $error("edge select upper bits not one");
    apb_ready_a: assert property (i_psel && !i_penable |=> o_pready ##1 !o_pready)
        else $error("ready not one cycle after setup");
endmodule // exc_ctrl_properties

bind exc_ctrl exc_ctrl_properties chk_u (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n),
    .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
    .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
    .i_request_pin(i_request_pin), .i_wakeup_pin(i_wakeup_pin),
    .i_internal_src(i_internal_src), .i_insn_boundary(i_insn_boundary),
    .i_cond_code_ibit(i_cond_code_ibit), .o_core_hold(o_core_hold),
    .o_periph_init(o_periph_init), .o_ibit_set(o_ibit_set), .o_pc_load(o_pc_load),
    .o_int_start(o_int_start), .o_vector_num(o_vector_num), .o_vector_addr(o_vector_addr));

// file: verif/core_model.sv
// Behavioural model of the CPU core beside the exception controller
`timescale 1ns/1ps
module core_model
(
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    input wire logic i_core_hold,
    input wire logic i_ibit_set,
    input wire logic i_int_start,
    input wire logic i_unmask,
    output logic o_insn_boundary,
    output logic o_cond_code_ibit
);
    logic [1:0] step_q;

    // Ends an instruction every fourth cycle while not held
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
            step_q <= 2'h0;
        else
            step_q <= i_core_hold ? 2'h0 : step_q + 2'h1;
    end

    // One-cycle boundary pulse at the end of each instruction
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_insn_boundary <= 1'b0;
        else
            o_insn_boundary <= !i_core_hold && step_q == 2'h3;
    end

    // Mask bit: set by reset and on exception entry, cleared by software
    always_ff @(posedge i_clk_sys or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_cond_code_ibit <= 1'b1;
        else if (i_ibit_set || i_int_start)
            o_cond_code_ibit <= 1'b1;
        else if (i_unmask)
            o_cond_code_ibit <= 1'b0;
    end
endmodule // core_model

// file: verif/reset_and_interrupt_exception_control_tb.sv
// Self-checking bench for the exception controller
`timescale 1ns/1ps
module reset_and_interrupt_exception_control_tb;
    typedef struct packed
    {
        logic wr;
        logic [17:0] addr;
        logic [7:0] wdata;
        logic [7:0] rdata;
    } row_type;

    // ----------------------------------------------------------------
    // Signals and instances
    // ----------------------------------------------------------------
    logic clk_sys = 1'b0;
    logic rst_n = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h00000000;
    logic [4:0] req_pin = 5'h0d;
    logic [7:0] wk_pin = 8'hff;
    logic [23:0] int_src = 24'h000000;
    logic unmask = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, boundary, ibit, hold, pinit, ibit_set, pc_load, int_start;
    logic [4:0] vnum;
    logic [15:0] vaddr;
    int error_cnt = 0;
    int num_checks = 0;
    row_type rows [12] = '{{1'b0, 18'h3fe40, 8'h00, 8'h00}, {1'b0, 18'h3ffc8, 8'h00, 8'he0},
        {1'b0, 18'h3ffcc, 8'h00, 8'h00}, {1'b0, 18'h3ffd0, 8'h00, 8'h00},
        {1'b0, 18'h3ffd8, 8'h00, 8'h20}, {1'b0, 18'h3ffdc, 8'h00, 8'h00},
        {1'b0, 18'h3ffe4, 8'h00, 8'h00}, {1'b1, 18'h3ffc8, 8'h02, 8'he2},
        {1'b1, 18'h3ffcc, 8'h23, 8'h23}, {1'b1, 18'h3ffd0, 8'ha2, 8'ha2},
        {1'b1, 18'h3ffd8, 8'hff, 8'h20}, {1'b1, 18'h3ffdc, 8'hff, 8'h00}};
    logic [4:0] vec [5] = '{5'h04, 5'h05, 5'h09, 5'h0d, 5'h14};
    logic [25:0] clr [5] = '{{18'h3ffd8, 8'hfe}, {18'h3ffd8, 8'hfc}, {18'h3ffe4, 8'h00},
        {18'h3ffdc, 8'hfd}, {18'h3ffdc, 8'h7d}};

    exc_ctrl dut_u (.i_clk_sys(clk_sys), .i_reset_n(rst_n), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_request_pin(req_pin), .i_wakeup_pin(wk_pin),
        .i_internal_src(int_src), .i_insn_boundary(boundary), .i_cond_code_ibit(ibit),
        .o_core_hold(hold), .o_periph_init(pinit), .o_ibit_set(ibit_set), .o_pc_load(pc_load),
        .o_int_start(int_start), .o_vector_num(vnum), .o_vector_addr(vaddr));
    core_model core_u (.i_clk_sys(clk_sys), .i_reset_n(rst_n), .i_core_hold(hold),
        .i_ibit_set(ibit_set), .i_int_start(int_start), .i_unmask(unmask),
        .o_insn_boundary(boundary), .o_cond_code_ibit(ibit));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        num_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    // One APB transfer, held until ready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [17:0] a, input logic [7:0] d,
        output logic [7:0] rd, output logic err);
        int n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1 && n < 20)
        begin
            n++;
            @(posedge clk_sys);
        end
        chk({15'h0000, pready}, 16'h0001, "ready");
        rd = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Holds reset, then waits for the init pulses
    task automatic do_reset(input int cycles);
        int n = 0;
        rst_n <= 1'b0;
        repeat (cycles) @(posedge clk_sys);
        chk({14'h0, hold, pinit}, 16'h0003, "held in reset");
        rst_n <= 1'b1;
        while (ibit_set !== 1'b1 && n < 10)
        begin
            n++;
            @(posedge clk_sys);
        end
        chk({14'h0, ibit_set, pc_load}, 16'h0003, "init pulses");
        chk(vaddr, 16'h0000, "reset vector");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and tests
    // ----------------------------------------------------------------
    initial
    begin
        forever #2 clk_sys = ~clk_sys;
    end

    initial
    begin
        #40000;
        error_cnt++;
        give_verdict();
    end

    initial
    begin
        int n;
        logic [7:0] rd;
        logic err;
        do_reset(6);
        $display("test power-up reset done");
        foreach (rows[i])
        begin
            if (rows[i].wr)
                apb(1'b1, rows[i].addr, rows[i].wdata, rd, err);
            apb(1'b0, rows[i].addr, 8'h00, rd, err);
            chk({7'h00, err, rd}, {8'h00, rows[i].rdata}, "register");
        end
        apb(1'b0, 18'h00100, 8'h00, rd, err);
        chk({7'h00, err, rd}, 16'h0100, "unmapped read");
        $display("test registers done");
        // Pin 0 falls, pin 1 rises, pin 4 rises on a falling select
        req_pin <= 5'h1e;
        wk_pin <= 8'h7f;
        int_src <= 24'h800008;
        repeat (8) @(posedge clk_sys);
        apb(1'b0, 18'h3ffd8, 8'h00, rd, err);
        chk({8'h00, rd}, 16'h0023, "request flags");
        apb(1'b0, 18'h3ffdc, 8'h00, rd, err);
        chk({8'h00, rd}, 16'h0082, "internal flags");
        apb(1'b0, 18'h3ffe4, 8'h00, rd, err);
        chk({8'h00, rd}, 16'h0080, "wakeup flags");
        for (int i = 0; i < 5; i++)
        begin
            n = 0;
            unmask <= 1'b1;
            @(posedge clk_sys);
            unmask <= 1'b0;
            while (int_start !== 1'b1 && n < 40)
            begin
                n++;
                @(posedge clk_sys);
            end
            chk({15'h0000, int_start}, 16'h0001, "start");
            chk({11'h000, vnum}, {11'h000, vec[i]}, "vector number");
            chk(vaddr, {10'h000, vec[i], 1'b0}, "vector address");
            apb(1'b1, clr[i][25:8], clr[i][7:0], rd, err);
        end
        $display("test priority done");
        do_reset(10);
        apb(1'b0, 18'h3ffcc, 8'h00, rd, err);
        chk({8'h00, rd}, 16'h0000, "enable after reset");
        $display("test mid-run reset done");
        give_verdict();
    end
endmodule // reset_and_interrupt_exception_control_tb
